// ===== rtl/ccu_defines.vh
// ccu_defines.vh: register map, operation codes, alu function codes and flag positions
// assumes: included by the condition code unit files only
`ifndef CCU_DEFINES_VH
`define CCU_DEFINES_VH

// apb byte offsets
`define CCU_REG_SRC 8'h00
`define CCU_REG_DST 8'h04
`define CCU_REG_CMD 8'h08
`define CCU_REG_RESULT 8'h0C
`define CCU_REG_FLAGS 8'h10

// flag bit positions in the flags register
`define CCU_FLAG_C 0
`define CCU_FLAG_V 1
`define CCU_FLAG_Z 2
`define CCU_FLAG_N 3
`define CCU_FLAG_BUSY 4
`define CCU_FUNC_LSB 8
`define CCU_CARRY_IN_BIT 12

// operation codes written to the command register
`define CCU_OP_MOV 5'h00
`define CCU_OP_CMP 5'h01
`define CCU_OP_ADD 5'h02
`define CCU_OP_SUB 5'h03
`define CCU_OP_BIT 5'h04
`define CCU_OP_BIT_CLEAR 5'h05
`define CCU_OP_BIT_SET 5'h06
`define CCU_OP_XOR 5'h07
`define CCU_OP_CLR 5'h08
`define CCU_OP_COM 5'h09
`define CCU_OP_INC 5'h0A
`define CCU_OP_DECREMENT 5'h0B
`define CCU_OP_NEGATE 5'h0C
`define CCU_OP_ADC 5'h0D
`define CCU_OP_SUBTRACT_CARRY 5'h0E
`define CCU_OP_TEST 5'h0F
`define CCU_OP_ROR 5'h10
`define CCU_OP_ROL 5'h11
`define CCU_OP_ASR 5'h12
`define CCU_OP_ASL 5'h13
`define CCU_OP_BYTE_SWAP 5'h14
`define CCU_OP_MFP 5'h15
`define CCU_OP_MTP 5'h16

// alu function codes
`define CCU_FN_ZERO 4'h0
`define CCU_FN_NOTA 4'h1
`define CCU_FN_INCA 4'h2
`define CCU_FN_DECA 4'h3
`define CCU_FN_SUB 4'h4
`define CCU_FN_PASSA 4'h5
`define CCU_FN_PASSB 4'h6
`define CCU_FN_ADD 4'h8
`define CCU_FN_AND 4'h9
`define CCU_FN_ANDN 4'hA
`define CCU_FN_OR 4'hB
`define CCU_FN_XOR 4'hC

// special operand values
`define CCU_MOST_NEGATIVE 16'h8000
`define CCU_MOST_POS 16'h7FFF
`define CCU_ALL_ONES 16'hFFFF

`endif

// ===== rtl/ccu_func_rom.v
// ccu_func_rom.v: auxiliary setup decode of operation to alu function code
// assumes: setup is a one-cycle strobe from the sequencer in the same clock domain
`include "ccu_defines.vh"
`default_nettype none

module ccu_func_rom (
	input wire clk,
	input wire rst,
	input wire setup,
	input wire [4:0] op,
	input wire carry_flag_value,
	output reg [3:0] func_code
);

function [3:0] decode_func;
	input [4:0] o;
	input c;
	begin
		case (o)
			`CCU_OP_CMP, `CCU_OP_SUB, `CCU_OP_NEGATE: decode_func = `CCU_FN_SUB;
			`CCU_OP_ADD: decode_func = `CCU_FN_ADD;
			`CCU_OP_BIT: decode_func = `CCU_FN_AND;
			`CCU_OP_BIT_CLEAR: decode_func = `CCU_FN_ANDN;
			`CCU_OP_BIT_SET: decode_func = `CCU_FN_OR;
			`CCU_OP_XOR: decode_func = `CCU_FN_XOR;
			`CCU_OP_CLR: decode_func = `CCU_FN_ZERO;
			`CCU_OP_COM: decode_func = `CCU_FN_NOTA;
			`CCU_OP_INC: decode_func = `CCU_FN_INCA;
			`CCU_OP_DECREMENT: decode_func = `CCU_FN_DECA;
			// carry picks between pass and step
			`CCU_OP_ADC: decode_func = c ? `CCU_FN_INCA : `CCU_FN_PASSA;
			`CCU_OP_SUBTRACT_CARRY: decode_func = c ? `CCU_FN_DECA : `CCU_FN_PASSA;
			`CCU_OP_ROR, `CCU_OP_ROL, `CCU_OP_ASR, `CCU_OP_ASL: decode_func = `CCU_FN_PASSB;
			default: decode_func = `CCU_FN_PASSA;
		endcase
	end
endfunction

always @(posedge clk) begin
	if (rst) begin
		func_code <= `CCU_FN_ZERO;
	end else if (setup) begin
		func_code <= decode_func(op, carry_flag_value);
	end
end

endmodule

`default_nettype wire

// ===== rtl/ccu_core.v
// ccu_core.v: condition code update and alu control with an apb register file
// assumes: single 125 MHz clock, synchronous active-high reset, zero-wait apb master
`include "ccu_defines.vh"
`default_nettype none

module ccu_core (
	input wire CLK_SYS,
	input wire RST,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	output wire [3:0] FUNC_CODE,
	output reg ALU_CARRY_IN,
	output reg [3:0] COND_CODES,
	output wire BUSY
);

localparam ST_IDLE = 2'h0;
localparam ST_SETUP = 2'h1;
localparam ST_EXEC = 2'h2;

reg [1:0] state;
reg [15:0] src;
reg [15:0] dst;
reg [15:0] breg;
reg [4:0] op;
reg [15:0] result;
reg [15:0] next_result;
reg [3:0] next_cc;
reg next_carry_in;
reg [31:0] rd_word;
reg [16:0] sum;
wire carry_flag_value;
wire aux_setup;
wire access;
wire mapped;

////////////////////////////////////////////////////////////////////////////////
// apb slave

assign access = PSEL && PENABLE;
assign PREADY = 1'b1;
assign mapped = (PADDR == `CCU_REG_SRC) || (PADDR == `CCU_REG_DST) ||
	(PADDR == `CCU_REG_CMD) || (PADDR == `CCU_REG_RESULT) || (PADDR == `CCU_REG_FLAGS);
assign PSLVERR = access && !mapped;
assign BUSY = (state != ST_IDLE);
assign carry_flag_value = COND_CODES[`CCU_FLAG_C];

always @* begin
	if (PADDR == `CCU_REG_SRC) begin
		rd_word = {16'h0000, src};
	end else if (PADDR == `CCU_REG_DST) begin
		rd_word = {16'h0000, dst};
	end else if (PADDR == `CCU_REG_CMD) begin
		rd_word = {27'h0000000, op};
	end else if (PADDR == `CCU_REG_RESULT) begin
		rd_word = {16'h0000, result};
	end else if (PADDR == `CCU_REG_FLAGS) begin
		rd_word = {19'h00000, ALU_CARRY_IN, FUNC_CODE, 3'h0, BUSY, COND_CODES};
	end else begin
		rd_word = 32'h00000000;
	end
end

// read data caught in the setup phase so it stands through the access phase;
// a flags read overlapping an op may show state one cycle old
always @(posedge CLK_SYS) begin
	if (RST) begin
		PRDATA <= 32'h00000000;
	end else if (PSEL && !PENABLE) begin
		PRDATA <= rd_word;
	end
end

////////////////////////////////////////////////////////////////////////////////
// auxiliary setup decode

assign aux_setup = (state == ST_SETUP);

ccu_func_rom u_rom (
	.clk(CLK_SYS),
	.rst(RST),
	.setup(aux_setup),
	.op(op),
	.carry_flag_value(carry_flag_value),
	.func_code(FUNC_CODE)
);

////////////////////////////////////////////////////////////////////////////////
// alu and condition code decision

function is_rot;
	input [4:0] o;
	begin
		is_rot = (o == `CCU_OP_ROR) || (o == `CCU_OP_ROL) ||
			(o == `CCU_OP_ASR) || (o == `CCU_OP_ASL);
	end
endfunction

function [15:0] alu;
	input [3:0] fn;
	input [15:0] a;
	input [15:0] b;
	begin
		case (fn)
			`CCU_FN_ZERO: alu = 16'h0000;
			`CCU_FN_NOTA: alu = ~a;
			`CCU_FN_INCA: alu = a + 16'h0001;
			`CCU_FN_DECA: alu = a - 16'h0001;
			`CCU_FN_SUB: alu = a - b;
			`CCU_FN_PASSB: alu = b;
			`CCU_FN_ADD: alu = a + b;
			`CCU_FN_AND: alu = a & b;
			`CCU_FN_ANDN: alu = ~a & b;
			`CCU_FN_OR: alu = a | b;
			`CCU_FN_XOR: alu = a ^ b;
			default: alu = a;
		endcase
	end
endfunction

always @* begin
	next_cc = COND_CODES;
	next_carry_in = 1'b0;
	sum = {1'b0, dst} + {1'b0, src};
	// negate runs as zero minus destination
	if (op == `CCU_OP_NEGATE) begin
		next_result = 16'h0000 - dst;
	end else if (op == `CCU_OP_SUB || op == `CCU_OP_CMP) begin
		next_result = dst - src;
	end else begin
		next_result = alu(FUNC_CODE, dst, breg);
	end
	case (op)
		`CCU_OP_ADD: begin
			next_result = sum[15:0];
			next_cc[`CCU_FLAG_V] = (dst[15] == src[15]) && (sum[15] != src[15]);
			next_cc[`CCU_FLAG_C] = sum[16];
		end
		`CCU_OP_SUB, `CCU_OP_CMP: begin
			next_cc[`CCU_FLAG_V] = (dst[15] != src[15]) && (next_result[15] == src[15]);
			next_cc[`CCU_FLAG_C] = (dst < src);
		end
		`CCU_OP_INC: begin
			next_carry_in = 1'b1;
			next_cc[`CCU_FLAG_V] = (dst == `CCU_MOST_NEGATIVE);
		end
		`CCU_OP_DECREMENT: begin
			next_carry_in = 1'b1;
			next_cc[`CCU_FLAG_V] = (next_result == `CCU_MOST_NEGATIVE);
		end
		`CCU_OP_NEGATE: begin
			next_cc[`CCU_FLAG_C] = (next_result != 16'h0000);
			next_cc[`CCU_FLAG_V] = (next_result == `CCU_MOST_NEGATIVE);
		end
		`CCU_OP_ADC: begin
			next_cc[`CCU_FLAG_V] = (dst == `CCU_MOST_POS) && carry_flag_value;
			next_cc[`CCU_FLAG_C] = (dst == `CCU_ALL_ONES) && carry_flag_value;
		end
		`CCU_OP_SUBTRACT_CARRY: begin
			next_cc[`CCU_FLAG_V] = (dst == `CCU_MOST_NEGATIVE);
			next_cc[`CCU_FLAG_C] = (dst == 16'h0000) && carry_flag_value;
		end
		`CCU_OP_CLR, `CCU_OP_TEST: begin
			next_cc[`CCU_FLAG_V] = 1'b0;
			next_cc[`CCU_FLAG_C] = 1'b0;
		end
		`CCU_OP_COM: begin
			next_cc[`CCU_FLAG_V] = 1'b0;
			next_cc[`CCU_FLAG_C] = 1'b1;
		end
		`CCU_OP_BYTE_SWAP: begin
			next_result = {dst[7:0], dst[15:8]};
			next_cc[`CCU_FLAG_V] = 1'b0;
			next_cc[`CCU_FLAG_C] = 1'b0;
		end
		`CCU_OP_ROR: begin
			next_result = {carry_flag_value, breg[15:1]};
			next_cc[`CCU_FLAG_C] = breg[0];
		end
		`CCU_OP_ROL: begin
			next_result = {breg[14:0], carry_flag_value};
			next_cc[`CCU_FLAG_C] = breg[15];
		end
		`CCU_OP_ASR: begin
			next_result = {breg[15], breg[15:1]};
			next_cc[`CCU_FLAG_C] = breg[0];
		end
		`CCU_OP_ASL: begin
			next_result = {breg[14:0], 1'b0};
			next_cc[`CCU_FLAG_C] = breg[15];
		end
		default: begin
			// moves, bit ops, xor and mode-space moves keep carry
			next_cc[`CCU_FLAG_V] = 1'b0;
		end
	endcase
	next_cc[`CCU_FLAG_N] = next_result[15];
	next_cc[`CCU_FLAG_Z] = (next_result == 16'h0000);
end

////////////////////////////////////////////////////////////////////////////////
// sequencer and registers

always @(posedge CLK_SYS) begin
	if (RST) begin
		state <= ST_IDLE;
		src <= 16'h0000;
		dst <= 16'h0000;
		breg <= 16'h0000;
		op <= 5'h00;
		result <= 16'h0000;
		COND_CODES <= 4'h0;
		ALU_CARRY_IN <= 1'b0;
	end else begin
		case (state)
			ST_IDLE: begin
				// writes while busy are dropped so operands stay stable
				if (access && PWRITE) begin
					if (PADDR == `CCU_REG_SRC) begin
						src <= PWDATA[15:0];
					end else if (PADDR == `CCU_REG_DST) begin
						dst <= PWDATA[15:0];
					end else if (PADDR == `CCU_REG_FLAGS) begin
						COND_CODES <= PWDATA[3:0];
					end else if (PADDR == `CCU_REG_CMD) begin
						op <= PWDATA[4:0];
						state <= ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				// setup rides on the b-to-b copy step, costing no extra cycle
				if (is_rot(op)) begin
					breg <= dst;
				end else begin
					breg <= src;
				end
				state <= ST_EXEC;
			end
			ST_EXEC: begin
				result <= next_result;
				COND_CODES <= next_cc;
				ALU_CARRY_IN <= next_carry_in;
				state <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
			end
		endcase
	end
end

endmodule

`default_nettype wire

// ===== tb/ccu_monitor.sv
// ccu_monitor.sv: port checks of the condition code unit
// assumes: bound to ccu_core, single clock, synchronous reset
`include "ccu_defines.vh"
`default_nettype none
module ccu_monitor (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [3:0] FUNC_CODE,
	input wire logic ALU_CARRY_IN,
	input wire logic [3:0] COND_CODES,
	input wire logic BUSY
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);
	logic acc;
	logic cmd;
	logic [4:0] op;
	assign acc = PSEL && PENABLE;
	assign cmd = acc && PWRITE && PADDR == `CCU_REG_CMD && !BUSY;
	assign op = PWDATA[4:0];
	////////////////////////////////////////////////////////////////
	busy_len_a: assert property (cmd |=> BUSY [*2] ##1 !BUSY)
		else $error("busy length wrong");
	add_func_a: assert property (cmd && op == `CCU_OP_ADD |=> ##1 FUNC_CODE == `CCU_FN_ADD)
		else $error("add function code wrong");
	sub_func_a: assert property (cmd && op == `CCU_OP_SUB |=> ##1 FUNC_CODE == `CCU_FN_SUB)
		else $error("sub function code wrong");
	shift_func_a: assert property (cmd && op inside {[`CCU_OP_ROR:`CCU_OP_ASL]}
		|=> ##1 FUNC_CODE == `CCU_FN_PASSB)
		else $error("shift setup code wrong");
	step_carry_a: assert property (cmd && op inside {`CCU_OP_INC, `CCU_OP_DECREMENT}
		|-> ##3 ALU_CARRY_IN)
		else $error("carry-in not one");
	logic_carry_a: assert property (cmd && op inside {[`CCU_OP_MOV:`CCU_OP_XOR],
		`CCU_OP_TEST, `CCU_OP_BYTE_SWAP} |-> ##3 !ALU_CARRY_IN)
		else $error("carry-in not zero");
	flag_hold_a: assert property (!BUSY && !(acc && PWRITE && PADDR == `CCU_REG_FLAGS)
		|=> $stable(COND_CODES))
		else $error("flags moved while idle");
	err_map_a: assert property (acc |-> PSLVERR == !(PADDR inside {`CCU_REG_SRC, `CCU_REG_DST,
		`CCU_REG_CMD, `CCU_REG_RESULT, `CCU_REG_FLAGS}))
		else $error("slave error wrong");
	ready_now_a: assert property (PSEL |-> PREADY)
		else $error("ready low");
	rst_clear_a: assert property ($fell(RST) |-> COND_CODES == 4'h0 && !BUSY && FUNC_CODE == 4'h0)
		else $error("reset state wrong");
	cover property (cmd && op == `CCU_OP_ADC);
	cover property (acc && PSLVERR);
	cover property ($fell(BUSY));
endmodule
bind ccu_core ccu_monitor u_ccu_monitor (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .FUNC_CODE(FUNC_CODE), .ALU_CARRY_IN(ALU_CARRY_IN),
	.COND_CODES(COND_CODES), .BUSY(BUSY));
`default_nettype wire

// ===== tb/ccu_apb_master.sv
// ccu_apb_master.sv: apb master standing in for the sequencer side
// assumes: shares the slave clock
`default_nettype none
module ccu_apb_master (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 8'hFF;
		pwdata = 0;
	end
	// released address and data lines invert so a stale value never passes
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		// no wait limit here: a hung slave is caught by the bench watchdog
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ===== tb/ccu_core_test.sv
// ccu_core_test.sv: random and corner tests of the condition code unit
// assumes: apb master model and monitor compiled first
`include "ccu_defines.vh"
`default_nettype none
module ccu_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0;
	logic rst = 1;
	logic psel, penable, pwrite, pready, pslverr, carry_in, busy, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [31:0] x = 32'hE27D;
	logic [3:0] fn, cc;
	logic [24:0] ex;
	logic [15:0] d;
	int num_errors = 0;
	int cmp_count = 0;
	logic [4:0] ops [23] = '{`CCU_OP_ADD, `CCU_OP_SUB, `CCU_OP_INC, `CCU_OP_DECREMENT,
		`CCU_OP_NEGATE, `CCU_OP_ADC, `CCU_OP_SUBTRACT_CARRY, `CCU_OP_XOR, `CCU_OP_COM,
		`CCU_OP_CLR, `CCU_OP_TEST, `CCU_OP_ROR, `CCU_OP_ROL, `CCU_OP_ASR, `CCU_OP_ASL,
		`CCU_OP_MOV, `CCU_OP_BIT, `CCU_OP_BIT_CLEAR, `CCU_OP_BIT_SET, `CCU_OP_BYTE_SWAP,
		`CCU_OP_CMP, `CCU_OP_MFP, `CCU_OP_MTP};
	logic [15:0] cor [4] = '{16'h8000, 16'h7FFF, 16'hFFFF, 16'h0000};
	always #4 clk = ~clk;
	ccu_core u_ccu_core (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .FUNC_CODE(fn), .ALU_CARRY_IN(carry_in), .COND_CODES(cc),
		.BUSY(busy));
	ccu_apb_master u_ccu_apb_master (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// packs {carry-in, function code, n z v c, result}
	function automatic logic [24:0] ref_op(logic [4:0] o, logic [15:0] s, a, logic [3:0] f);
		logic [16:0] t;
		logic v, c, ci;
		logic [3:0] k;
		t = {1'b0, a};
		v = 0;
		c = f[0];
		ci = 0;
		k = `CCU_FN_PASSA;
		case (o)
			`CCU_OP_ADD: begin
				t = a + s;
				v = a[15] == s[15] && t[15] != s[15];
				c = t[16];
				k = `CCU_FN_ADD;
			end
			`CCU_OP_SUB, `CCU_OP_CMP: begin
				t = a - s;
				v = a[15] != s[15] && t[15] == s[15];
				c = a < s;
				k = `CCU_FN_SUB;
			end
			`CCU_OP_INC: begin
				t = a + 1;
				v = a == 16'h8000;
				ci = 1;
				k = `CCU_FN_INCA;
			end
			`CCU_OP_DECREMENT: begin
				t = a - 1;
				v = t[15:0] == 16'h8000;
				ci = 1;
				k = `CCU_FN_DECA;
			end
			`CCU_OP_NEGATE: begin
				t = 0 - a;
				v = t[15:0] == 16'h8000;
				c = t[15:0] != 0;
				k = `CCU_FN_SUB;
			end
			`CCU_OP_ADC: begin
				t = a + f[0];
				v = a == 16'h7FFF && f[0];
				c = a == 16'hFFFF && f[0];
				k = f[0] ? `CCU_FN_INCA : `CCU_FN_PASSA;
			end
			`CCU_OP_SUBTRACT_CARRY: begin
				t = a - f[0];
				v = a == 16'h8000;
				c = a == 0 && f[0];
				k = f[0] ? `CCU_FN_DECA : `CCU_FN_PASSA;
			end
			`CCU_OP_XOR: begin
				t = a ^ s;
				k = `CCU_FN_XOR;
			end
			`CCU_OP_COM: begin
				t = ~a;
				c = 1;
				k = `CCU_FN_NOTA;
			end
			`CCU_OP_CLR: begin
				t = 0;
				c = 0;
				k = `CCU_FN_ZERO;
			end
			`CCU_OP_BIT: begin
				t = a & s;
				k = `CCU_FN_AND;
			end
			`CCU_OP_BIT_CLEAR: begin
				t = ~a & s;
				k = `CCU_FN_ANDN;
			end
			`CCU_OP_BIT_SET: begin
				t = a | s;
				k = `CCU_FN_OR;
			end
			`CCU_OP_BYTE_SWAP: begin
				t = {a[7:0], a[15:8]};
				c = 0;
			end
			// rotates and shifts leave overflow alone
			`CCU_OP_ROR, `CCU_OP_ASR: begin
				t = {o == `CCU_OP_ROR ? f[0] : a[15], a[15:1]};
				v = f[1];
				c = a[0];
				k = `CCU_FN_PASSB;
			end
			`CCU_OP_ROL, `CCU_OP_ASL: begin
				t = {a[14:0], o == `CCU_OP_ROL ? f[0] : 1'b0};
				v = f[1];
				c = a[15];
				k = `CCU_FN_PASSB;
			end
			`CCU_OP_TEST: c = 0;
			default: c = f[0];
		endcase
		return {ci, k, t[15], t[15:0] == 0, v, c, t[15:0]};
	endfunction
	task automatic chk(string nm, logic [31:0] want, logic [31:0] got);
		cmp_count++;
		if (got !== want) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, want, got);
		end
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] v);
		u_ccu_apb_master.xfer(w, a, v, r, e);
	endtask
	task automatic run(logic [4:0] o, logic [15:0] s, a, logic [3:0] f);
		bus(1, `CCU_REG_SRC, {16'h0, s});
		bus(1, `CCU_REG_DST, {16'h0, a});
		bus(1, `CCU_REG_FLAGS, {28'h0, f});
		bus(1, `CCU_REG_CMD, {27'h0, o});
		do @(posedge clk); while (busy !== 1'b0);
	endtask
	task automatic test_done();
		if (num_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		test_done();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		bus(0, `CCU_REG_FLAGS, 0);
		chk("reset flags", 0, r);
		for (int i = 0; i < 184; i++) begin
			x = lfsr(x);
			d = i < 92 ? cor[i / 23] : x[31:16];
			run(ops[i % 23], x[15:0], d, x[3:0]);
			ex = ref_op(ops[i % 23], x[15:0], d, x[3:0]);
			bus(0, `CCU_REG_RESULT, 0);
			chk("result", {16'h0, ex[15:0]}, r);
			bus(0, `CCU_REG_FLAGS, 0);
			chk("flags", {19'h0, ex[24:20], 4'h0, ex[19:16]}, r);
			chk("codes", {28'h0, ex[19:16]}, {28'h0, cc});
			chk("alu carry-in", {31'h0, ex[24]}, {31'h0, carry_in});
			chk("func code", {28'h0, ex[23:20]}, {28'h0, fn});
		end
		for (int j = 11; j < 20; j++) begin
			x = lfsr(x);
			run(ops[j], x[15:0], x[31:16], x[3:0]);
			chk("alu carry-in", 0, {31'h0, carry_in});
		end
		bus(0, 8'h14 | x[7:0], 0);
		chk("unmapped err", 1, {31'h0, e});
		chk("unmapped data", 0, r);
		test_done();
	end
endmodule
`default_nettype wire
